// file: sto_pkg.sv
// Constants and types shared by the torque-off interlock
package sto_pkg;
    // Control clock rate
    localparam int unsigned CLK_KHZ       = 20000;
    // Pulse tolerance of each channel, in microseconds
    localparam int unsigned PULSE_TOL_US  = 1000;
    // Allowed skew between the two channels, in milliseconds
    localparam int unsigned SKEW_MS       = 200;
    // Cycle counts derived from the times above
    localparam int unsigned FILT_CYCLES   = (PULSE_TOL_US * CLK_KHZ) / 1000;
    localparam int unsigned SKEW_CYCLES   = SKEW_MS * CLK_KHZ;
    // Fault codes for loss of one channel only, and the no-fault code
    localparam logic [15:0] CODE_CH1_LOSS = 16'hFA81;
    localparam logic [15:0] CODE_CH2_LOSS = 16'hFA82;
    localparam logic [15:0] CODE_NONE     = 16'h0000;
    // Indication selection per drive state
    typedef enum logic [1:0] {
        IND_NONE    = 2'h0,
        IND_WARNING = 2'h1,
        IND_FAULT   = 2'h2
    } ind_t;
    // Drive states, one-hot
    typedef enum logic [1:0] {
        ST_STOPPED = 2'h1,
        ST_RUN     = 2'h2
    } drive_state_t;
endpackage

// file: sto_chan_if.sv
// Raw and filtered torque-off channels between core and filter
`timescale 1ns/10ps
interface sto_chan_if;
    logic [1:0] raw;
    logic [1:0] act;
    modport filt (input raw, output act);
    modport core (output raw, input act);
endinterface

// file: sto_chan_filter.sv
// Per-channel synchroniser and pulse filter for the torque-off inputs
`timescale 1ns/10ps
module sto_chan_filter #(
    parameter int unsigned FILT_CYCLES = sto_pkg::FILT_CYCLES
) (
    input wire logic   clk,
    input wire logic   rst_b,
    sto_chan_if.filt   chan
);
    localparam int unsigned CW = $clog2(FILT_CYCLES + 1);
    localparam logic [CW-1:0] CNT_MAX = CW'(FILT_CYCLES);

    // Each channel is its own path; no logic is shared between them
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_chan
            logic          s1_q;
            logic          s2_q;
            logic          act_q;
            logic [CW-1:0] cnt_q;

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                end else begin
                    s1_q <= chan.raw[i];
                    s2_q <= s1_q;
                end
            end

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    cnt_q <= '0;
                    act_q <= 1'b0; // Safe side: de-energized until proven
                end else if (s2_q == act_q) begin
                    cnt_q <= '0;
                end else if (cnt_q == CNT_MAX) begin
                    act_q <= s2_q;
                    cnt_q <= '0;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end

            assign chan.act[i] = act_q;
        end
    endgenerate
endmodule // sto_chan_filter

// file: sto_interlock.sv
// Dual-channel safe torque off interlock core
`timescale 1ns/10ps
// Contract
// - Request forces both channels de-energized
// - De-energized inputs drop gate enable immediately
// - Selection picks none, warning or fault
// - Separate selection for running and stopped
// - Selection never affects gate removal
// - Running drive coasts on any loss
// - No start until inputs restored, faults reset
// - Single channel loss past the skew window faults
// - Reset needed only if fault raised
// - Restart needs a fresh start edge
// - Start while de-energized gives warning
// - Distinct codes for channel one, two
// - Ignore dropouts up to pulse tolerance
module sto_interlock #(
    parameter int unsigned FILT_CYCLES = sto_pkg::FILT_CYCLES,
    parameter int unsigned SKEW_CYCLES = sto_pkg::SKEW_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        sto_in_1,
    input  wire logic        sto_in_2,
    input  wire logic        sto_request,
    input  wire logic        start_cmd,
    input  wire logic        stop_cmd,
    input  wire logic        fault_reset,
    input  wire logic [1:0]  running_ind_sel,
    input  wire logic [1:0]  stopped_ind_sel,
    output logic             gate_enable,
    output logic             drive_running,
    output logic             warning,
    output logic             fault,
    output logic [15:0]      fault_code
);
    localparam int unsigned SW = $clog2(SKEW_CYCLES + 1);
    localparam logic [SW-1:0] SKEW_MAX = SW'(SKEW_CYCLES);

    // Latency budget, pin to gate: two sync stages, FILT_CYCLES+1 filter cycles,
    // then one more edge for the gate register. A change on a pin takes about
    // FILT_CYCLES+4 edges to reach the gate. That is four edges past the pulse tolerance.
    // The filter delay is the price of ignoring short contact bounce.
    sto_chan_if chan ();

    logic [1:0]              ch_ok;
    logic                    both_on;
    logic                    both_on_q;
    logic                    start_prev_q;
    logic                    start_edge;
    logic [SW-1:0]           skew_q;
    logic                    mismatch_flt;
    logic [1:0]              sel;
    logic                    loss_event;
    sto_pkg::drive_state_t   state_q;
    logic                    warn_q;
    logic                    fault_q;
    logic [15:0]             code_q;
    logic                    gate_q;

    assign chan.raw = {sto_in_2, sto_in_1};

    sto_chan_filter #(
        .FILT_CYCLES (FILT_CYCLES)
    ) u_filter (
        .clk   (clk),
        .rst_b (rst_b),
        .chan  (chan.filt)
    );

    // The request bypasses the filter on purpose. A commanded stop must not
    // wait out the pulse tolerance, and a glitch on it only stops torque,
    // which is the safe direction.
    // request overrides both inputs
    assign ch_ok   = chan.act & {2{~sto_request}};
    assign both_on = &ch_ok;

    // Previous input state, for detecting the moment of loss
    // Resets low, so a power-up with inputs off gives no loss event
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            both_on_q <= 1'b0;
        end else begin
            both_on_q <= both_on;
        end
    end
    assign loss_event = both_on_q & ~both_on;

    // Start edge; reset value 1 so a level held through reset is no edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_prev_q <= 1'b1;
        end else begin
            start_prev_q <= start_cmd;
        end
    end
    assign start_edge = start_cmd & ~start_prev_q;

    // Channel discrepancy timer; partner is allowed the skew window
    // Counts only while the filtered channels disagree, and holds at the limit
    // so that a lasting wiring fault keeps the fault latch set. Both channels
    // off together is a normal stop, not a discrepancy.
    // Limitation: a discrepancy shorter than the window is never reported.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            skew_q <= '0;
        end else if (ch_ok[0] == ch_ok[1]) begin
            skew_q <= '0;
        end else if (skew_q != SKEW_MAX) begin
            skew_q <= skew_q + 1'b1;
        end
    end
    // mismatch beyond skew is wiring fault
    assign mismatch_flt = (skew_q == SKEW_MAX);

    assign sel = (state_q == sto_pkg::ST_RUN) ? running_ind_sel : stopped_ind_sel;

    // Drive state machine
    // Two one-hot states. RUN is entered only on a fresh start edge with both
    // channels on, no latched fault and no discrepancy. Any loss, stop or
    // discrepancy returns to STOPPED in one edge. The default branch pulls an
    // illegal code back to the safe state.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= sto_pkg::ST_STOPPED;
        end else begin
            case (state_q)
                sto_pkg::ST_STOPPED: begin
                    // start blocked by inputs or fault
                    if (start_edge && both_on && !fault_q && !mismatch_flt) begin
                        state_q <= sto_pkg::ST_RUN;
                    end
                end
                sto_pkg::ST_RUN: begin
                    if (!both_on || stop_cmd || mismatch_flt) begin
                        state_q <= sto_pkg::ST_STOPPED;
                    end
                end
                default: begin
                    state_q <= sto_pkg::ST_STOPPED;
                end
            endcase
        end
    end

    // Gate enable drops on the inputs directly, never on the indication selection
    // The gate is a register of its own, not a decode of the state, so that
    // the loss path drops it at the same edge as the state leaves RUN.
    // The selection inputs appear nowhere in this process.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gate_q <= 1'b0;
        end else if (!both_on) begin
            gate_q <= 1'b0;
        end else begin
            gate_q <= (state_q == sto_pkg::ST_RUN) && !stop_cmd && !mismatch_flt;
        end
    end

    // Warning: clears once both inputs are back
    // A set in the same cycle as the restore wins, so a start refused at the
    // last moment is still reported
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            warn_q <= 1'b0;
        end else if (start_edge && !both_on && state_q == sto_pkg::ST_STOPPED) begin
            warn_q <= 1'b1;
        end else if (loss_event && sel == sto_pkg::IND_WARNING) begin
            warn_q <= 1'b1;
        end else if (both_on) begin
            warn_q <= 1'b0;
        end
    end

    // Fault latch; a new fault in the reset cycle wins over the reset
    // The code is written only for a discrepancy. A fault from the selection
    // leaves the code at none, so software can tell a wiring fault from a
    // configured stop.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_q <= 1'b0;
            code_q  <= sto_pkg::CODE_NONE;
        end else if (mismatch_flt) begin
            fault_q <= 1'b1;
            code_q  <= ch_ok[0] ? sto_pkg::CODE_CH2_LOSS : sto_pkg::CODE_CH1_LOSS;
        end else if (loss_event && sel == sto_pkg::IND_FAULT) begin
            fault_q <= 1'b1;
        // reset clears only with inputs back
        end else if (fault_reset && both_on) begin
            fault_q <= 1'b0;
            code_q  <= sto_pkg::CODE_NONE;
        end
    end

    // Registered outputs; every one is a flop with no logic after it
    // The running flag is the RUN bit of the one-hot state register
    assign gate_enable   = gate_q;
    assign drive_running = state_q[1];
    assign warning       = warn_q;
    assign fault         = fault_q;
    assign fault_code    = code_q;
endmodule // sto_interlock

// file: sto_interlock_props.sv
// Port checks for the torque-off interlock
`timescale 1ns/10ps
module sto_interlock_props #(
    parameter int unsigned FILT_CYCLES = sto_pkg::FILT_CYCLES,
    parameter int unsigned SKEW_CYCLES = sto_pkg::SKEW_CYCLES
) (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        sto_in_1,
    input wire logic        sto_in_2,
    input wire logic        sto_request,
    input wire logic        start_cmd,
    input wire logic        stop_cmd,
    input wire logic        fault_reset,
    input wire logic [1:0]  running_ind_sel,
    input wire logic [1:0]  stopped_ind_sel,
    input wire logic        gate_enable,
    input wire logic        drive_running,
    input wire logic        warning,
    input wire logic        fault,
    input wire logic [15:0] fault_code
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    int unsigned mis_cnt;
    // Pin mismatch length; saturates so a long fault cannot wrap it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) mis_cnt <= 0;
        else if (sto_in_1 == sto_in_2) mis_cnt <= 0;
        else if (mis_cnt < SKEW_CYCLES + FILT_CYCLES + 8) mis_cnt <= mis_cnt + 1;
    end
    sequence s_start; $rose(drive_running) && !sto_request; endsequence
    property p_req_gate; sto_request |=> !gate_enable; endproperty
    a_req_gate: assert property (p_req_gate) else $error("gate on under request");
    property p_start_gate; s_start |=> gate_enable; endproperty
    a_start_gate: assert property (p_start_gate) else $error("gate late after run");
    property p_gate_run; gate_enable |-> $past(drive_running); endproperty
    a_gate_run: assert property (p_gate_run) else $error("gate without run");
    property p_fresh; s_start |-> $past(start_cmd) && !$past(start_cmd, 2); endproperty
    a_fresh: assert property (p_fresh) else $error("run without start");
    property p_no_fault_run; $rose(drive_running) |-> !$past(fault); endproperty
    a_no_fault_run: assert property (p_no_fault_run) else $error("run over fault");
    property p_code_fault; fault_code != 16'h0000 |-> fault; endproperty
    a_code_fault: assert property (p_code_fault) else $error("code without fault");
    property p_fault_hold; fault && !fault_reset |=> fault; endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault lost");
    property p_single; mis_cnt == SKEW_CYCLES + FILT_CYCLES + 8 |-> fault && !gate_enable;
    endproperty
    a_single: assert property (p_single) else $error("mismatch not faulted");
endmodule // sto_interlock_props
bind sto_interlock sto_interlock_props #(.FILT_CYCLES(FILT_CYCLES), .SKEW_CYCLES(SKEW_CYCLES))
    u_props (.clk(clk), .rst_b(rst_b), .sto_in_1(sto_in_1), .sto_in_2(sto_in_2),
    .sto_request(sto_request), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
    .fault_reset(fault_reset), .running_ind_sel(running_ind_sel),
    .stopped_ind_sel(stopped_ind_sel), .gate_enable(gate_enable),
    .drive_running(drive_running), .warning(warning), .fault(fault),
    .fault_code(fault_code));

// file: sto_switch_model.sv
// Two-contact safety relay driving the torque-off pins
`timescale 1ns/10ps
module sto_switch_model (
    input wire logic       clk,
    input wire logic       open_req,
    input wire logic [1:0] cut,
    output logic           ch_1,
    output logic           ch_2
);
    logic [2:0] lag_q = 3'h0;
    always @(negedge clk) lag_q <= {lag_q[1:0], open_req};
    // Contacts closed unless opened, or one cut as a wiring fault
    assign ch_1 = !open_req && !cut[0];
    assign ch_2 = !lag_q[2] && !cut[1];
endmodule // sto_switch_model

// file: tb_safe_torque_off_interlock.sv
// Self-checking bench for the torque-off interlock
`timescale 1ns/10ps
module tb_safe_torque_off_interlock;
    localparam int unsigned SKEW = 20;
    logic        clk = 1'b0, rst_b = 1'b0, req = 1'b0, start = 1'b1, stop = 1'b0;
    logic        frst = 1'b0, open_req = 1'b0, ch_1, ch_2, gate, run, warn, flt;
    logic [1:0]  rsel = 2'h0, ssel = 2'h0, cut = 2'h0;
    logic [15:0] code;
    int          error_cnt = 0, check_count = 0;
    // Free-running 20 MHz clock
    always #25 clk = ~clk;
    sto_switch_model u_relay (.clk(clk), .open_req(open_req), .cut(cut), .ch_1(ch_1),
        .ch_2(ch_2));
    sto_interlock #(.FILT_CYCLES(4), .SKEW_CYCLES(SKEW)) uut (.clk(clk), .rst_b(rst_b),
        .sto_in_1(ch_1), .sto_in_2(ch_2), .sto_request(req), .start_cmd(start),
        .stop_cmd(stop), .fault_reset(frst), .running_ind_sel(rsel),
        .stopped_ind_sel(ssel), .gate_enable(gate), .drive_running(run),
        .warning(warn), .fault(flt), .fault_code(code));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Fresh start edge, then time for run and gate
    task automatic go;
        start = 1'b0;
        cyc(1);
        start = 1'b1;
        cyc(3);
    endtask
    task automatic clear;
        frst = 1'b1;
        cyc(1);
        frst = 1'b0;
        cyc(2);
    endtask
    task automatic t_reset;
        cyc(12);
        chk(gate | run, 1'b0);
        go(); chk(gate, 1'b1);
    endtask
    // Request under every selection while running
    task automatic t_request;
        for (int s = 0; s < 4; s++) begin
            rsel = 2'(s);
            req = 1'b1;
            cyc(2);
            chk(gate, 1'b0);
            chk({warn, flt}, {s == 1, s == 2});
            req = 1'b0;
            cyc(8);
            chk(run | flt !== (s == 2), 1'b0);
            clear(); go(); chk(gate, 1'b1);
        end
    endtask
    // Loss while stopped uses the stopped selection
    task automatic t_stopped;
        rsel = 2'h2;
        stop = 1'b1;
        cyc(1);
        stop = 1'b0;
        open_req = 1'b1;
        cyc(15);
        chk({run, warn, flt}, 3'h0);
        go(); chk({gate, warn}, 2'h1);
        open_req = 1'b0;
        cyc(15);
        go(); chk(gate, 1'b1);
        ssel = 2'h2;
        stop = 1'b1;
        cyc(1);
        stop = 1'b0;
        open_req = 1'b1;
        cyc(15);
        chk({run, warn, flt}, 3'h1);
        open_req = 1'b0;
        cyc(15);
        go(); chk(gate, 1'b0);
        clear(); go(); chk(gate, 1'b1);
        ssel = 2'h0;
    endtask
    // One contact cut past the skew limit
    task automatic t_single;
        rsel = 2'h0;
        for (int c = 0; c < 2; c++) begin
            cut = c ? 2'h2 : 2'h1;
            cyc(SKEW + 14);
            chk(code, c ? sto_pkg::CODE_CH2_LOSS : sto_pkg::CODE_CH1_LOSS);
            chk({flt, gate}, 2'h2);
            go(); chk(run, 1'b0);
            cut = 2'h0;
            cyc(12);
            clear(); chk(code, sto_pkg::CODE_NONE);
            go(); chk(gate, 1'b1);
        end
    endtask
    // Dropout as long as the pulse tolerance
    task automatic t_glitch;
        cut = 2'h1;
        cyc(4);
        cut = 2'h0;
        cyc(12);
        chk({gate, flt}, 2'h2);
    endtask
    task automatic results;
        if (error_cnt == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Main sequence, reset held five cycles
    initial begin
        cyc(5);
        rst_b = 1'b1;
        t_reset();
        t_request();
        t_stopped();
        t_single();
        t_glitch();
        results();
    end
    // Watchdog, several times the expected run length
    initial begin
        #100000;
        error_cnt++;
        results();
    end
endmodule // tb_safe_torque_off_interlock
